// *** inc/ufh_defs.vh ***
// constants for the usb function handshake, timer and wakeup block
// Summary of operation
// - timer start reservation reloads to 01h at reset and on valid setup.
// - setup is valid only with address match, endpoint 0 and no token error.
// - after-transmit start bit starts timer at clean data transmit eop.
// - after-token start bit starts timer at clean out/setup token eop to endpoint 0.
// - d- and d+ level bits select forced low at 0, high at 1.
// - line force enable picks transmit buffer at 0, level bits at 1.
// - resume output bit 1 enables the pins; at 0 the pins are off when forced, else follow the transmit buffer enable.
// - the usb timer is a 7-bit counter for packet timing and runaway detection.
// - high-speed mode counts fx and acts as a 6-bit counter.
// - low-speed mode counts the usb clock, 1.5 mhz at 6.0 mhz fx.
// - high-speed mode starts at reserved token eop or data transmit eop.
// - low-speed mode starts on receive sync, usb reset or resume.
// - timer overflow raises the timer interrupt request in both modes.
// - low-speed overflow sets runaway error and stops the usb clock.
// - ack reservation sends ack at clean data receive eop.
// - data-save nak sends nak at clean out data eop without runaway error.
// - endpoint 0 stall reservation sends stall at clean in token eop to endpoint 0.
`ifndef UFH_DEFS_VH
`define UFH_DEFS_VH
`define UFH_ADDR_REMWAKE 16'hff6a
`define UFH_ADDR_TSTART 16'hff6c
`define UFH_REMWAKE_RST 8'h08
`define UFH_TSTART_RST 8'h01
`define UFH_BIT_WAKEUP 0
`define UFH_BIT_FORCE 1
`define UFH_BIT_DPLUS 2
`define UFH_BIT_DMINUS 3
`define UFH_BIT_AFTER_TOKEN 0
`define UFH_BIT_AFTER_TX 1
`define UFH_FX_KHZ 6000
`define UFH_USBCLK_KHZ 1500
`define UFH_SLOW_DIV (`UFH_FX_KHZ / `UFH_USBCLK_KHZ)
`define UFH_TIMER_W 7
`define UFH_FAST_W 6
`define UFH_HS_NONE 3'h0
`define UFH_HS_ACK 3'h1
`define UFH_HS_NAK 3'h2
`define UFH_HS_STALL 3'h3
`define UFH_HS_BUF0 3'h4
`define UFH_HS_BUF1 3'h5
`endif

// *** hw/ufh_top.v ***
// usb function handshake reservation, usb timer and remote wakeup logic
`timescale 1ns/100ps
`default_nettype none
`include "ufh_defs.vh"
module ufh_top #(
    parameter TIMER_W = `UFH_TIMER_W,
    parameter FAST_W = `UFH_FAST_W,
    parameter SLOW_DIV = `UFH_SLOW_DIV
) (
    input wire clk,
    input wire sys_rst,
    input wire [15:0] cpu_addr,
    input wire [7:0] cpu_wdata,
    input wire cpu_wr,
    input wire cpu_rd,
    output reg [7:0] cpu_rdata,
    input wire ep0_buf0_send_reserve,
    input wire ep0_buf1_send_reserve,
    input wire ep0_stall_reserve,
    input wire ep0_nak_reserve,
    input wire ep1_buf0_send_reserve,
    input wire ep1_buf1_send_reserve,
    input wire ep1_stall_reserve,
    input wire ep1_nak_reserve,
    input wire length_error_stall_reserve,
    input wire data_save_nak_reserve,
    input wire data_ok_ack_reserve,
    input wire token_eop,
    input wire data_rx_eop,
    input wire data_tx_eop,
    input wire out_token_seen,
    input wire setup_token_seen,
    input wire in_token_seen,
    input wire token_pid_match,
    input wire address_match,
    input wire endpoint_zero_hit,
    input wire endpoint_one_hit,
    input wire token_byte_error,
    input wire token_bit_error,
    input wire token_crc5_error,
    input wire data_pid_match,
    input wire data_byte_length_error,
    input wire data_bit_error,
    input wire data_crc16_error,
    input wire sync_detect,
    input wire reset_resume_detect,
    input wire runaway_clear,
    input wire tx_buf_dplus,
    input wire tx_buf_dminus,
    input wire tx_buf_oe,
    output reg hs_send,
    output reg [2:0] hs_kind,
    output reg timer_overflow_irq,
    output reg clock_runaway_error,
    output reg usb_clk_run,
    output reg [TIMER_W-1:0] timer_count,
    output reg timer_slow_mode,
    output reg dplus_out,
    output reg dminus_out,
    output reg line_oe
);

////////////////////////////////////////////////////////////////////////
// condition functions

function tok_ok;
    input byte_err;
    input bit_err;
    input crc_err;
    begin
        tok_ok = ~byte_err & ~bit_err & ~crc_err;
    end
endfunction

function dat_ok;
    input pid_ok;
    input byte_err;
    input bit_err;
    input crc_err;
    begin
        dat_ok = pid_ok & ~byte_err & ~bit_err & ~crc_err;
    end
endfunction

////////////////////////////////////////////////////////////////////////
// registers

reg [7:0] remote_wakeup_control;
reg [7:0] timer_start_reservation;

wire token_clean;
wire data_clean;
wire setup_valid;
wire wr_remwake;
wire wr_tstart;

assign token_clean = tok_ok(token_byte_error, token_bit_error, token_crc5_error);
assign data_clean = dat_ok(data_pid_match, data_byte_length_error, data_bit_error, data_crc16_error);
// valid setup needs address, endpoint 0 and a clean token
assign setup_valid = token_eop & setup_token_seen & address_match & endpoint_zero_hit & token_clean;
assign wr_remwake = cpu_wr & (cpu_addr == `UFH_ADDR_REMWAKE);
assign wr_tstart = cpu_wr & (cpu_addr == `UFH_ADDR_TSTART);

always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        remote_wakeup_control <= `UFH_REMWAKE_RST;
        timer_start_reservation <= `UFH_TSTART_RST;
    end else begin
        if (wr_remwake) begin
            remote_wakeup_control <= {4'h0, cpu_wdata[3:0]};
        end
        // setup reload wins over a software write in the same cycle
        if (setup_valid) begin
            timer_start_reservation <= `UFH_TSTART_RST;
        end else if (wr_tstart) begin
            timer_start_reservation <= {6'h00, cpu_wdata[1:0]};
        end
    end
end

always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        cpu_rdata <= 8'h00;
    end else if (cpu_rd) begin
        if (cpu_addr == `UFH_ADDR_REMWAKE) begin
            cpu_rdata <= remote_wakeup_control;
        end else if (cpu_addr == `UFH_ADDR_TSTART) begin
            cpu_rdata <= timer_start_reservation;
        end else begin
            cpu_rdata <= 8'h00;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// handshake and data transmit selection

reg [2:0] next_hs_kind;
wire in_ep0;
wire in_ep1;

// every ep0 response, sends included, requires the token pid to match as well
assign in_ep0 = token_eop & in_token_seen & token_pid_match & address_match & endpoint_zero_hit & token_clean;
assign in_ep1 = token_eop & in_token_seen & address_match & endpoint_one_hit & token_clean;

// one packet per eop, first matching reservation only
always @* begin
    next_hs_kind = `UFH_HS_NONE;
    if (in_ep0) begin
        if (ep0_buf0_send_reserve) begin
            next_hs_kind = `UFH_HS_BUF0;
        end else if (ep0_buf1_send_reserve) begin
            next_hs_kind = `UFH_HS_BUF1;
        end else if (ep0_stall_reserve) begin
            next_hs_kind = `UFH_HS_STALL;
        end else if (ep0_nak_reserve) begin
            next_hs_kind = `UFH_HS_NAK;
        end
    end else if (in_ep1) begin
        if (ep1_buf0_send_reserve) begin
            next_hs_kind = `UFH_HS_BUF0;
        end else if (ep1_buf1_send_reserve) begin
            next_hs_kind = `UFH_HS_BUF1;
        end else if (ep1_stall_reserve) begin
            next_hs_kind = `UFH_HS_STALL;
        end else if (ep1_nak_reserve) begin
            next_hs_kind = `UFH_HS_NAK;
        end
    end else if (data_rx_eop) begin
        if (data_save_nak_reserve & out_token_seen & data_clean & ~clock_runaway_error) begin
            next_hs_kind = `UFH_HS_NAK;
        end else if (data_ok_ack_reserve & data_clean) begin
            next_hs_kind = `UFH_HS_ACK;
        end else if (length_error_stall_reserve & ~data_pid_match & ~data_bit_error) begin
            next_hs_kind = `UFH_HS_STALL;
        end
    end
end

always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        hs_send <= 1'b0;
        hs_kind <= `UFH_HS_NONE;
    end else begin
        hs_send <= (next_hs_kind != `UFH_HS_NONE);
        hs_kind <= next_hs_kind;
    end
end

////////////////////////////////////////////////////////////////////////
// usb timer

reg [3:0] slow_div_cnt;
wire start_fast;
wire start_slow;
wire slow_tick;
wire count_en;
wire at_top;
wire [TIMER_W-1:0] next_count;
reg timer_run;

// reserved fast starts after a clean token or a clean data transmit
assign start_fast = (timer_start_reservation[`UFH_BIT_AFTER_TOKEN] & token_eop
                     & (out_token_seen | setup_token_seen) & address_match
                     & endpoint_zero_hit & token_clean)
                  | (timer_start_reservation[`UFH_BIT_AFTER_TX] & data_tx_eop
                     & data_clean);
assign start_slow = sync_detect | reset_resume_detect;
// usb clock tick derived from fx, only while the usb clock runs
assign slow_tick = usb_clk_run & (slow_div_cnt == SLOW_DIV[3:0] - 4'h1);
assign count_en = timer_run & (timer_slow_mode ? slow_tick : 1'b1);
assign at_top = timer_slow_mode ? (&timer_count) : (&timer_count[FAST_W-1:0]);
assign next_count = timer_count + {{(TIMER_W-1){1'b0}}, 1'b1};

always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        slow_div_cnt <= 4'h0;
    end else if (~usb_clk_run | slow_tick) begin
        slow_div_cnt <= 4'h0;
    end else begin
        slow_div_cnt <= slow_div_cnt + 4'h1;
    end
end

always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        timer_count <= {TIMER_W{1'b0}};
        timer_run <= 1'b0;
        timer_slow_mode <= 1'b0;
        timer_overflow_irq <= 1'b0;
    end else begin
        timer_overflow_irq <= 1'b0;
        if (start_slow) begin
            timer_count <= {TIMER_W{1'b0}};
            timer_run <= 1'b1;
            timer_slow_mode <= 1'b1;
        end else if (start_fast) begin
            timer_count <= {TIMER_W{1'b0}};
            timer_run <= 1'b1;
            timer_slow_mode <= 1'b0;
        end else if (count_en) begin
            if (at_top) begin
                // wrap back to zero and stop
                timer_count <= {TIMER_W{1'b0}};
                timer_run <= 1'b0;
                timer_overflow_irq <= 1'b1;
            end else if (timer_slow_mode) begin
                timer_count <= next_count;
            end else begin
                timer_count <= {1'b0, next_count[FAST_W-1:0]};
            end
        end
    end
end

// runaway flag and usb clock gate
wire slow_ovf;
assign slow_ovf = count_en & at_top & timer_slow_mode & ~start_slow & ~start_fast;

always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        clock_runaway_error <= 1'b0;
        usb_clk_run <= 1'b1;
    end else begin
        // set wins over clear
        if (slow_ovf) begin
            clock_runaway_error <= 1'b1;
        end else if (runaway_clear) begin
            clock_runaway_error <= 1'b0;
        end
        if (slow_ovf) begin
            usb_clk_run <= 1'b0;
        end else if (reset_resume_detect) begin
            usb_clk_run <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// line driver and remote wakeup

wire force_en;
wire wake_on;
assign force_en = remote_wakeup_control[`UFH_BIT_FORCE];
assign wake_on = remote_wakeup_control[`UFH_BIT_WAKEUP];

always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        dplus_out <= 1'b0;
        dminus_out <= 1'b0;
        line_oe <= 1'b0;
    end else if (force_en) begin
        dplus_out <= remote_wakeup_control[`UFH_BIT_DPLUS];
        dminus_out <= remote_wakeup_control[`UFH_BIT_DMINUS];
        line_oe <= wake_on;
    end else begin
        dplus_out <= tx_buf_dplus;
        dminus_out <= tx_buf_dminus;
        line_oe <= tx_buf_oe | wake_on;
    end
end

endmodule // ufh_top
`default_nettype wire

// *** tb/ufh_sva.sv ***
// assertion checker for the usb handshake, timer and wakeup block
`timescale 1ns/100ps
`default_nettype none
`include "ufh_defs.vh"
module ufh_sva #(
    parameter TIMER_W = 7
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [15:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic cpu_wr,
    input wire logic token_eop,
    input wire logic data_rx_eop,
    input wire logic data_tx_eop,
    input wire logic data_ok_ack_reserve,
    input wire logic data_save_nak_reserve,
    input wire logic data_pid_match,
    input wire logic data_byte_length_error,
    input wire logic data_bit_error,
    input wire logic data_crc16_error,
    input wire logic sync_detect,
    input wire logic reset_resume_detect,
    input wire logic tx_buf_dplus,
    input wire logic tx_buf_oe,
    input wire logic hs_send,
    input wire logic [2:0] hs_kind,
    input wire logic timer_overflow_irq,
    input wire logic clock_runaway_error,
    input wire logic usb_clk_run,
    input wire logic [TIMER_W-1:0] timer_count,
    input wire logic timer_slow_mode,
    input wire logic dplus_out,
    input wire logic dminus_out,
    input wire logic line_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire wr_wake = cpu_wr && cpu_addr == `UFH_ADDR_REMWAKE;
    wire clean = data_pid_match && !data_byte_length_error && !data_bit_error && !data_crc16_error;
    wire starts = token_eop || data_tx_eop || sync_detect || reset_resume_detect;
    ////////////////////////////////////////////////////////////////////////////////
    chk_ack_send:
    assert property (data_rx_eop && !token_eop && data_ok_ack_reserve && !data_save_nak_reserve && clean
        |=> hs_send && hs_kind == `UFH_HS_ACK) else $error("ack not sent");
    chk_quiet_no_eop:
    assert property (!token_eop && !data_rx_eop |=> !hs_send) else $error("packet without eop");
    chk_force_levels:
    assert property (wr_wake && cpu_wdata[1] ##1 !wr_wake |=> dplus_out == $past(cpu_wdata[2], 2)
        && dminus_out == $past(cpu_wdata[3], 2) && line_oe == $past(cpu_wdata[0], 2)) else $error("forced pins");
    chk_tx_follow:
    assert property (wr_wake && cpu_wdata[1:0] == 2'h0 ##1 !wr_wake
        |=> dplus_out == $past(tx_buf_dplus) && line_oe == $past(tx_buf_oe)) else $error("tx path");
    chk_fast_wrap:
    assert property (!timer_slow_mode && timer_count == 63 && !starts
        |=> timer_overflow_irq && timer_count == 0) else $error("fast wrap");
    chk_fast_width:
    assert property (!timer_slow_mode |-> timer_count < 64) else $error("fast width");
    chk_slow_start:
    assert property (sync_detect |=> timer_slow_mode && timer_count == 0) else $error("slow start");
    chk_resume_run:
    assert property (reset_resume_detect |=> usb_clk_run) else $error("clock not restarted");
    chk_runaway_stop:
    assert property ($rose(clock_runaway_error) |-> timer_overflow_irq && !usb_clk_run) else $error("runaway");
    cover property (hs_send && hs_kind == `UFH_HS_STALL);
    cover property ($rose(clock_runaway_error));
    cover property (timer_overflow_irq && !timer_slow_mode);
endmodule // ufh_sva
bind ufh_top ufh_sva #(.TIMER_W(TIMER_W)) u_ufh_sva (.*);
`default_nettype wire

// *** tb/ufh_host.sv ***
// usb host model: packet end events with qualifier levels
`timescale 1ns/100ps
`default_nettype none
module ufh_host (
    input wire logic clk,
    input wire logic go,
    input wire logic [1:0] kind,
    input wire logic [13:0] q_in,
    output logic [3:0] eop,
    output logic [13:0] q
);
    initial eop = 4'h0;
    initial q = 14'h0;
    // one eop pulse per packet; qualifiers toggle outside it
    always @(posedge clk) begin
        eop <= 4'h0;
        q <= go ? q_in : ~q;
        if (go) begin
            eop[kind] <= 1'b1;
        end
    end
endmodule // ufh_host
`default_nettype wire

// *** tb/test_ufh_top.sv ***
// testbench for the usb handshake, timer and wakeup block
`timescale 1ns/100ps
`default_nettype none
`include "ufh_defs.vh"
module test_ufh_top;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] cpu_addr = 16'h0;
    logic [7:0] cpu_wdata = 8'h0;
    logic cpu_wr = 1'b0;
    logic cpu_rd = 1'b0;
    logic sync_detect = 1'b0;
    logic runaway_clear = 1'b0;
    logic go = 1'b0;
    logic [1:0] kind = 2'h0;
    logic [13:0] q_in = 14'h0;
    logic [10:0] rsv = 11'h0;
    logic [2:0] txb = 3'h0;
    logic [3:0] eop;
    logic [13:0] q;
    logic [13:0] v;
    logic [10:0] nr;
    int i, j, n, num_checks, n_mismatch;
    wire [7:0] cpu_rdata;
    wire [2:0] hs_kind;
    wire [6:0] timer_count;
    wire hs_send, timer_overflow_irq, clock_runaway_error, usb_clk_run, timer_slow_mode, dplus_out, dminus_out, line_oe;
    always #5 clk = ~clk;
    ufh_host u_ufh_host (.*);
    ufh_top u_ufh_top (.*,
        .ep0_buf0_send_reserve(rsv[10]), .ep0_buf1_send_reserve(rsv[9]), .ep0_stall_reserve(rsv[8]),
        .ep0_nak_reserve(rsv[7]), .ep1_buf0_send_reserve(rsv[6]), .ep1_buf1_send_reserve(rsv[5]),
        .ep1_stall_reserve(rsv[4]), .ep1_nak_reserve(rsv[3]), .length_error_stall_reserve(rsv[2]),
        .data_save_nak_reserve(rsv[1]), .data_ok_ack_reserve(rsv[0]), .token_eop(eop[0]),
        .data_rx_eop(eop[1]), .data_tx_eop(eop[2]), .reset_resume_detect(eop[3]),
        .out_token_seen(q[13]), .setup_token_seen(q[12]), .in_token_seen(q[11]), .token_pid_match(q[10]),
        .address_match(q[9]), .endpoint_zero_hit(q[8]), .endpoint_one_hit(q[7]), .token_byte_error(q[6]),
        .token_bit_error(q[5]), .token_crc5_error(q[4]), .data_pid_match(q[3]),
        .data_byte_length_error(q[2]), .data_bit_error(q[1]), .data_crc16_error(q[0]),
        .tx_buf_dplus(txb[0]), .tx_buf_dminus(txb[1]), .tx_buf_oe(txb[2]));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic [7:0] exp_hs(input [10:0] r, input [1:0] k, input [13:0] x);
        logic tk;
        logic dc;
        logic [3:0] s;
        begin
            tk = x[11] && x[9] && x[6:4] == 3'h0;
            dc = x[3] && x[2:0] == 3'h0;
            s = (tk && x[10] && x[8]) ? r[10:7] : (tk && x[7]) ? r[6:3] : 4'h0;
            exp_hs = s[3] ? 8'h0c : s[2] ? 8'h0d : s[1] ? 8'h0b : s[0] ? 8'h0a : 8'h00;
            if (k == 2'h1) begin
                exp_hs = (r[1] && x[13] && dc) ? 8'h0a : (r[0] && dc) ? 8'h09 : (r[2] && !x[3] && !x[1]) ? 8'h0b : 8'h00;
            end
        end
    endfunction
    function automatic [7:0] exp_pin(input [3:0] w, input [2:0] t);
        exp_pin = w[1] ? {5'h0, w[3], w[2], w[0]} : {5'h0, t[1], t[0], t[2] | w[0]};
    endfunction
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        cpu_addr = a;
        cpu_wdata = d;
        cpu_wr = 1'b1;
        @(posedge clk) #1;
        cpu_wr = 1'b0;
        @(posedge clk) #1;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        cpu_addr = a;
        cpu_rd = 1'b1;
        @(posedge clk) #1;
        cpu_rd = 1'b0;
        cmp(cpu_rdata, e);
        @(posedge clk) #1;
    endtask
    task automatic host(input logic [1:0] k, input logic [13:0] x);
        kind = k;
        q_in = x;
        go = 1'b1;
        @(posedge clk) #1;
        go = 1'b0;
        @(posedge clk) #1;
    endtask
    task automatic scan(input int lim, input logic slow);
        n = 0;
        for (int c = 1; c <= lim && n == 0; c++) begin
            @(posedge clk) #1;
            if ((slow ? clock_runaway_error : timer_overflow_irq) === 1'b1) n = c;
        end
    endtask
    task automatic summarize;
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        n_mismatch++;
        summarize();
    end
    initial begin
        void'($urandom(32'h18a9ce54));
        repeat (6) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        rd(`UFH_ADDR_REMWAKE, `UFH_REMWAKE_RST);
        rd(`UFH_ADDR_TSTART, `UFH_TSTART_RST);
        rd(16'hff00, 8'h00);
        for (i = 0; i < 16; i++) begin
            txb = $urandom;
            wr(`UFH_ADDR_REMWAKE, 8'(i));
            cmp({5'h0, dminus_out, dplus_out, line_oe}, exp_pin(i[3:0], txb));
            rd(`UFH_ADDR_REMWAKE, 8'(i));
        end
        wr(`UFH_ADDR_TSTART, 8'hfc);
        rd(`UFH_ADDR_TSTART, 8'h00);
        host(2'h0, 14'h1500);
        rd(`UFH_ADDR_TSTART, 8'h00);
        host(2'h0, 14'h1700);
        rd(`UFH_ADDR_TSTART, 8'h01);
        host(2'h0, 14'h2700);
        scan(70, 1'b0);
        cmp(8'(n), 8'd64);
        wr(`UFH_ADDR_TSTART, 8'h02);
        host(2'h2, 14'h0008);
        scan(70, 1'b0);
        cmp(8'(n), 8'd64);
        host(2'h0, 14'h2700);
        scan(70, 1'b0);
        cmp(8'(n), 8'd0);
        repeat (60) begin
            v = $urandom;
            if ($urandom % 4) v[11:9] = 3'h7;
            if ($urandom % 4) v[6:4] = 3'h0;
            if ($urandom % 4) v[3:0] = 4'h8;
            v[7] = !v[8];
            nr = 11'h0;
            j = $urandom % 5;
            if (j < 4) nr[10 - j] = 1'b1;
            j = $urandom % 5;
            if (j < 4) nr[6 - j] = 1'b1;
            j = $urandom % 4;
            if (j < 3) nr[2 - j] = 1'b1;
            rsv = nr;
            j = $urandom % 2;
            host(2'(j), v);
            cmp({4'h0, hs_send, hs_kind}, exp_hs(rsv, 2'(j), v));
        end
        sync_detect = 1'b1;
        @(posedge clk) #1;
        sync_detect = 1'b0;
        scan(600, 1'b1);
        cmp({6'h0, n > 500 && n < 530, usb_clk_run}, 8'h02);
        host(2'h3, 14'h0);
        cmp({7'h0, usb_clk_run}, 8'h01);
        runaway_clear = 1'b1;
        @(posedge clk) #1;
        runaway_clear = 1'b0;
        cmp({7'h0, clock_runaway_error}, 8'h00);
        summarize();
    end
endmodule // test_ufh_top
`default_nettype wire
